// [hw/irq_ctrl_pkg.sv]
// package: register map, field positions and types of the interrupt controller
package irq_ctrl_pkg;

    // register offsets
    localparam logic [7:0] TIMER_PIN_FLAG_CONTROL_OFS   = 8'h88;
    localparam logic [7:0] EXTENDED_LINE_FLAGS_OFS      = 8'h91;
    localparam logic [7:0] STOP_WAKE_SOURCE_MASK_OFS    = 8'h9F;
    localparam logic [7:0] PRIMARY_ENABLE_MASK_OFS      = 8'hA8;
    localparam logic [7:0] PRIMARY_PRIORITY_SELECT_OFS  = 8'hB8;
    localparam logic [7:0] LEVEL_STATUS_OFS             = 8'hC5;
    localparam logic [7:0] VECTOR_CONFIG_OFS            = 8'h9D;
    localparam logic [7:0] EXTENDED_ENABLE_MASK_OFS     = 8'hE8;
    localparam logic [7:0] EXTENDED_PRIORITY_SELECT_OFS = 8'hF8;

    // reset values
    localparam logic [7:0] REG_RESET_VAL  = 8'h00;
    localparam logic [7:0] WAKE_RESET_VAL = 8'hFF;

    // field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int TIMER_ONE_FLAG_BIT    = 7;
    localparam int TIMER_ONE_RUN_BIT     = 6;
    localparam int TIMER_ZERO_FLAG_BIT   = 5;
    localparam int TIMER_ZERO_RUN_BIT    = 4;
    localparam int PIN_B_FLAG_BIT        = 3;
    localparam int PIN_A_FLAG_BIT        = 1;
    localparam int HIGH_ACTIVE_BIT       = 6;
    localparam int LOW_ACTIVE_BIT        = 5;
    localparam int RELOCATE_BIT          = 5;
    localparam int I2C_HOST_FLAG_BIT     = 0;

    // source numbering (natural order, 0 served first within a priority level)
    localparam int NUM_SOURCES  = 15;
    localparam int SRC_PIN_A    = 0;
    localparam int SRC_TIMER0   = 1;
    localparam int SRC_PIN_B    = 2;
    localparam int SRC_TIMER1   = 3;
    localparam int SRC_SERIAL1  = 4;
    localparam int SRC_TIMER2   = 5;
    localparam int SRC_SERIAL2  = 6;
    localparam int SRC_I2C_HOST = 7;
    localparam int SRC_LINE2    = 8;

    // vectors
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam logic [15:0] VEC_MEM_ERROR = 16'h007B;
    localparam logic [11:0] VEC_BREAK_OFS = 12'h080;
    localparam logic [11:0] VEC_DEBUG_OFS = 12'h0C0;
    localparam int          VEC_STEP_LOG2 = 3;

    // top nibble of relocated vectors per memory size
    localparam logic [3:0] TOP_NIBBLE_64K = 4'hF;
    localparam logic [3:0] TOP_NIBBLE_48K = 4'hB;
    localparam logic [3:0] TOP_NIBBLE_32K = 4'h7;
    localparam logic [3:0] TOP_NIBBLE_16K = 4'h3;

    // request handed to the cpu sequencer
    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic        high;
        logic [4:0]  source;
    } irq_req_t;

    // register bus
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_bus_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_t;

endpackage

// [hw/two_level_interrupt_controller.sv]
// two-level priority interrupt controller with vector table and wake logic
module two_level_interrupt_controller
    import irq_ctrl_pkg::*;
#(
    parameter int         GPIO_PINS  = 8,
    parameter logic [3:0] TOP_NIBBLE = TOP_NIBBLE_64K
)(
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire reg_bus_t             bus,
    output logic [7:0]                rdata,
    input  wire logic                 timer_zero_overflow,
    input  wire logic                 timer_one_overflow,
    input  wire logic                 timer_two_overflow_flag,
    input  wire logic                 serial_one_irq,
    input  wire logic                 serial_two_irq,
    input  wire logic                 i2c_host_event,
    input  wire logic                 watchdog_flag,
    input  wire logic [6:0]           line_flags_in,
    input  wire logic                 mem_error_irq,
    input  wire logic                 breakpoint_irq,
    input  wire logic                 debug_port_irq,
    input  wire logic [GPIO_PINS-1:0] gpio_pins,
    input  wire logic [GPIO_PINS-1:0] gpio_group_b_sel,
    input  wire logic [GPIO_PINS-1:0] gpio_rise_en,
    input  wire logic [GPIO_PINS-1:0] gpio_fall_en,
    input  wire logic                 stop_mode,
    input  wire logic                 irq_ack,
    input  wire logic                 irq_return,
    output irq_req_t                  irq_req,
    output logic                      timer_zero_run,
    output logic                      timer_one_run,
    output logic                      wake_req,
    output logic                      osc_enable
);

    // refuse pin counts and memory size nibbles the logic cannot serve
    if (GPIO_PINS < 1 || GPIO_PINS > 64 || TOP_NIBBLE[1:0] != 2'b11) begin
        $error("gpio pin count or vector nibble out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0]           timer_pin_flag_control;
        logic                 i2c_flag;
        logic [7:0]           enable;
        logic [6:0]           prio;
        logic [7:0]           ext_enable;
        logic [7:0]           ext_prio;
        logic [7:0]           wake_mask;
        logic                 relocate;
        logic                 high_active;
        logic                 low_active;
        logic [7:0]           rdata;
        irq_req_t             req;
        seq_state_t           seq;
        logic                 wake;
        logic                 osc;
        logic [GPIO_PINS-1:0] gpio_s1;
        logic [GPIO_PINS-1:0] gpio_s2;
        logic [GPIO_PINS-1:0] gpio_s3;
        logic [GPIO_PINS-1:0] gpio_prev;
        logic [7:0]           wake_prev;
    } state_t;

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // combinational signals
    logic [NUM_SOURCES-1:0] pend;
    logic [NUM_SOURCES-1:0] enab;
    logic [NUM_SOURCES-1:0] hi;
    logic [GPIO_PINS-1:0]   gpio_stable;
    logic [GPIO_PINS-1:0]   gpio_edge;
    logic                   edge_a;
    logic                   edge_b;
    logic [7:0]             wake_lines;
    logic [7:0]             ext_flags;
    logic                   found_hi;
    logic                   found_lo;
    logic [4:0]             idx_hi;
    logic [4:0]             idx_lo;

    // gpio edge detection per pin; only stages two and three are compared
    genvar g;
    generate
        for (g = 0; g < GPIO_PINS; g++) begin : g_pin
            // a level counts once stage two and stage three agree
            assign gpio_stable[g] = (s_q.gpio_s2[g] == s_q.gpio_s3[g])
                                  ? s_q.gpio_s3[g] : s_q.gpio_prev[g];
            assign gpio_edge[g] =
                (gpio_rise_en[g] & gpio_stable[g] & ~s_q.gpio_prev[g]) |
                (gpio_fall_en[g] & ~gpio_stable[g] & s_q.gpio_prev[g]);
        end
    endgenerate

    assign edge_a = |(gpio_edge & ~gpio_group_b_sel);
    assign edge_b = |(gpio_edge & gpio_group_b_sel);

    // line flags are live peripheral flags, never latched here
    assign ext_flags = {line_flags_in[6:4], 1'b0, line_flags_in[2:0],
                        s_q.i2c_flag};

    // pending, enable and level vectors in natural order
    always_comb begin
        pend = {line_flags_in[6:4], watchdog_flag, line_flags_in[2:0],
                s_q.i2c_flag, serial_two_irq, timer_two_overflow_flag,
                serial_one_irq, s_q.timer_pin_flag_control[TIMER_ONE_FLAG_BIT],
                s_q.timer_pin_flag_control[PIN_B_FLAG_BIT], s_q.timer_pin_flag_control[TIMER_ZERO_FLAG_BIT],
                s_q.timer_pin_flag_control[PIN_A_FLAG_BIT]};
        enab = {s_q.ext_enable, s_q.enable[6:0]};
        hi   = {s_q.ext_prio, s_q.prio};
    end

    // fixed scan: highest index first so the lowest pending number remains
    always_comb begin
        found_hi = 1'b0;
        found_lo = 1'b0;
        idx_hi   = 5'h00;
        idx_lo   = 5'h00;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pend[i] && enab[i] && hi[i]) begin
                found_hi = 1'b1;
                idx_hi   = 5'(i);
            end
            if (pend[i] && enab[i] && !hi[i]) begin
                found_lo = 1'b1;
                idx_lo   = 5'(i);
            end
        end
    end

    // wake lines in mask order: 8,7,6,4,3,2, group b, group a
    assign wake_lines = {line_flags_in[6:4], line_flags_in[2:0],
                         edge_b, edge_a};

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic        gate;
        logic        take;
        logic [15:0] base;
        s_d  = s_q;
        gate = s_q.enable[GLOBAL_IRQ_ENABLE_BIT];
        take = 1'b0;
        base = 16'h0000;

        // input sampling on every clock edge
        s_d.gpio_s1   = gpio_pins;
        s_d.gpio_s2   = s_q.gpio_s1;
        s_d.gpio_s3   = s_q.gpio_s2;
        s_d.gpio_prev = gpio_stable;
        s_d.rdata     = 8'h00;

        // register writes; pin and i2c flag bits only clear, timer flag bits ignore writes
        if (bus.wr) begin
            if (bus.addr == TIMER_PIN_FLAG_CONTROL_OFS) begin
                s_d.timer_pin_flag_control[TIMER_ONE_RUN_BIT]  = bus.wdata[TIMER_ONE_RUN_BIT];
                s_d.timer_pin_flag_control[TIMER_ZERO_RUN_BIT] = bus.wdata[TIMER_ZERO_RUN_BIT];
                s_d.timer_pin_flag_control[PIN_B_FLAG_BIT] = s_q.timer_pin_flag_control[PIN_B_FLAG_BIT]
                                         & bus.wdata[PIN_B_FLAG_BIT];
                s_d.timer_pin_flag_control[PIN_A_FLAG_BIT] = s_q.timer_pin_flag_control[PIN_A_FLAG_BIT]
                                         & bus.wdata[PIN_A_FLAG_BIT];
            end else if (bus.addr == EXTENDED_LINE_FLAGS_OFS) begin
                s_d.i2c_flag = s_q.i2c_flag
                             & bus.wdata[I2C_HOST_FLAG_BIT];
            end else if (bus.addr == STOP_WAKE_SOURCE_MASK_OFS) begin
                s_d.wake_mask = bus.wdata;
            end else if (bus.addr == PRIMARY_ENABLE_MASK_OFS) begin
                s_d.enable = bus.wdata;
            end else if (bus.addr == PRIMARY_PRIORITY_SELECT_OFS) begin
                s_d.prio = bus.wdata[6:0];
            end else if (bus.addr == VECTOR_CONFIG_OFS) begin
                s_d.relocate = bus.wdata[RELOCATE_BIT];
            end else if (bus.addr == EXTENDED_ENABLE_MASK_OFS) begin
                s_d.ext_enable = bus.wdata;
            end else if (bus.addr == EXTENDED_PRIORITY_SELECT_OFS) begin
                s_d.ext_prio = bus.wdata;
            end
        end

        // register reads; unmapped addresses return zero
        if (bus.rd) begin
            if (bus.addr == TIMER_PIN_FLAG_CONTROL_OFS) begin
                s_d.rdata = s_q.timer_pin_flag_control;
            end else if (bus.addr == EXTENDED_LINE_FLAGS_OFS) begin
                s_d.rdata = ext_flags;
            end else if (bus.addr == STOP_WAKE_SOURCE_MASK_OFS) begin
                s_d.rdata = s_q.wake_mask;
            end else if (bus.addr == PRIMARY_ENABLE_MASK_OFS) begin
                s_d.rdata = s_q.enable;
            end else if (bus.addr == PRIMARY_PRIORITY_SELECT_OFS) begin
                s_d.rdata = {1'b0, s_q.prio};
            end else if (bus.addr == LEVEL_STATUS_OFS) begin
                s_d.rdata[HIGH_ACTIVE_BIT] = s_q.high_active;
                s_d.rdata[LOW_ACTIVE_BIT]  = s_q.low_active;
            end else if (bus.addr == VECTOR_CONFIG_OFS) begin
                s_d.rdata[RELOCATE_BIT] = s_q.relocate;
            end else if (bus.addr == EXTENDED_ENABLE_MASK_OFS) begin
                s_d.rdata = s_q.ext_enable;
            end else if (bus.addr == EXTENDED_PRIORITY_SELECT_OFS) begin
                s_d.rdata = s_q.ext_prio;
            end
        end

        // hardware sets come after software clears so a same-cycle event wins
        if (timer_zero_overflow) begin
            s_d.timer_pin_flag_control[TIMER_ZERO_FLAG_BIT] = 1'b1;
        end
        if (timer_one_overflow) begin
            s_d.timer_pin_flag_control[TIMER_ONE_FLAG_BIT] = 1'b1;
        end
        if (edge_a) begin
            s_d.timer_pin_flag_control[PIN_A_FLAG_BIT] = 1'b1;
        end
        if (edge_b) begin
            s_d.timer_pin_flag_control[PIN_B_FLAG_BIT] = 1'b1;
        end
        if (i2c_host_event) begin
            s_d.i2c_flag = 1'b1;
        end

        // return from a routine clears the innermost level first
        if (irq_return) begin
            if (s_q.high_active) begin
                s_d.high_active = 1'b0;
            end else begin
                s_d.low_active = 1'b0;
            end
        end

        // vector base: relocated region uses the memory size nibble
        if (s_q.relocate) begin
            base = {TOP_NIBBLE, 12'h000};
        end

        // request sequencer: hold the request until the cpu takes it
        case (s_q.seq)
            SEQ_IDLE: begin
                s_d.req.valid = 1'b0;
                if (debug_port_irq) begin
                    take = 1'b1;
                    s_d.req.vector = {TOP_NIBBLE, VEC_DEBUG_OFS};
                    s_d.req.high   = 1'b1;
                    s_d.req.source = 5'h11;
                end else if (breakpoint_irq) begin
                    take = 1'b1;
                    s_d.req.vector = {TOP_NIBBLE, VEC_BREAK_OFS};
                    s_d.req.high   = 1'b1;
                    s_d.req.source = 5'h10;
                end else if (gate && !s_q.high_active && found_hi) begin
                    take = 1'b1;
                    s_d.req.vector = base | (VEC_BASE +
                        16'({idx_hi, 3'b000}));
                    s_d.req.high   = 1'b1;
                    s_d.req.source = idx_hi;
                end else if (gate && mem_error_irq && !s_q.high_active
                             && !s_q.low_active) begin
                    take = 1'b1;
                    s_d.req.vector = base | VEC_MEM_ERROR;
                    s_d.req.high   = 1'b0;
                    s_d.req.source = 5'h0F;
                end else if (gate && !s_q.high_active && !s_q.low_active
                             && found_lo) begin
                    take = 1'b1;
                    s_d.req.vector = base | (VEC_BASE +
                        16'({idx_lo, 3'b000}));
                    s_d.req.high   = 1'b0;
                    s_d.req.source = idx_lo;
                end
                if (take) begin
                    s_d.req.valid = 1'b1;
                    s_d.seq       = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (irq_ack) begin
                    s_d.req.valid = 1'b0;
                    s_d.seq       = SEQ_IDLE;
                    if (s_q.req.high) begin
                        s_d.high_active = 1'b1;
                    end else begin
                        s_d.low_active = 1'b1;
                    end
                    // timer flags clear on entry unless re-raised now
                    if (s_q.req.source == 5'(SRC_TIMER0) &&
                        !timer_zero_overflow) begin
                        s_d.timer_pin_flag_control[TIMER_ZERO_FLAG_BIT] = 1'b0;
                    end
                    if (s_q.req.source == 5'(SRC_TIMER1) &&
                        !timer_one_overflow) begin
                        s_d.timer_pin_flag_control[TIMER_ONE_FLAG_BIT] = 1'b0;
                    end
                end
            end
            default: begin
                s_d.seq = SEQ_IDLE;
            end
        endcase

        // wake: rising edges of masked lines, independent of enables
        s_d.wake_prev = wake_lines;
        s_d.wake = stop_mode
                 & |(wake_lines & ~s_q.wake_prev & s_q.wake_mask);
        s_d.osc  = ~stop_mode | s_d.wake;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q           <= '0;
            s_q.wake_mask <= WAKE_RESET_VAL;
            s_q.enable    <= REG_RESET_VAL;
            s_q.seq       <= SEQ_IDLE;
            s_q.osc       <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign rdata          = s_q.rdata;
    assign irq_req        = s_q.req;
    assign timer_zero_run = s_q.timer_pin_flag_control[TIMER_ZERO_RUN_BIT];
    assign timer_one_run  = s_q.timer_pin_flag_control[TIMER_ONE_RUN_BIT];
    assign wake_req       = s_q.wake;
    assign osc_enable     = s_q.osc;

endmodule

// [testbench/cpu_seq_model.sv]
// cpu sequencer model: takes vectors after a delay, returns on demand
module cpu_seq_model
    import irq_ctrl_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset_n,
    input  wire irq_req_t irq_req,
    output logic          irq_ack,
    output logic          irq_return
);
    timeunit 1ns;
    timeprecision 1ps;
    int ack_dly = 2; // raised by the bench to act as a slow cpu
    int cnt;
    initial irq_return = 1'b0;
    // one ack per request, only while it stands, after ack_dly cycles
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ack <= 1'b0;
            cnt <= 0;
        end else begin
            irq_ack <= 1'b0;
            cnt <= 0;
            if (irq_req.valid && !irq_ack) begin
                if (cnt >= ack_dly)
                    irq_ack <= 1'b1;
                else
                    cnt <= cnt + 1;
            end
        end
    end
    // return from the running routine
    task automatic do_ret();
        @(posedge ref_clk);
        irq_return <= 1'b1;
        @(posedge ref_clk);
        irq_return <= 1'b0;
    endtask
endmodule

// [testbench/irq_ctrl_props.sv]
// checker: port timing of the interrupt controller
module irq_ctrl_props
    import irq_ctrl_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire reg_bus_t   bus,
    input wire logic [7:0] rdata,
    input wire logic       stop_mode,
    input wire logic       irq_ack,
    input wire irq_req_t   irq_req,
    input wire logic       timer_zero_run,
    input wire logic       timer_one_run,
    input wire logic       wake_req,
    input wire logic       osc_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // a write to the timer/pin register is the only way run bits move
    wire run_wr = bus.wr && bus.addr == TIMER_PIN_FLAG_CONTROL_OFS;
    ////////////////////////////////////////////////////////////////////
    a_req_stands: assert property (irq_req.valid && !irq_ack
        |=> $stable(irq_req)) else $error("request moved before ack");
    a_ack_drops: assert property (irq_ack && irq_req.valid
        |=> !irq_req.valid) else $error("request kept after ack");
    a_status_bits: assert property (bus.rd
        && bus.addr == LEVEL_STATUS_OFS |=> rdata[7] == 1'b0
        && rdata[4:0] == 5'h00) else $error("status spare bits set");
    a_idle_rdata: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    a_run_write: assert property (run_wr |=>
        timer_zero_run == $past(bus.wdata[TIMER_ZERO_RUN_BIT])
        && timer_one_run == $past(bus.wdata[TIMER_ONE_RUN_BIT]))
        else $error("run bits not written");
    a_run_hold: assert property (!run_wr |=> $stable(timer_zero_run)
        && $stable(timer_one_run)) else $error("run bits moved");
    a_osc_run: assert property (!stop_mode |=> osc_enable)
        else $error("oscillator off while running");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
    c_taken: cover property (irq_ack && irq_req.valid);
    c_wake: cover property (wake_req);
    c_run: cover property (run_wr);
endmodule
bind two_level_interrupt_controller irq_ctrl_props u_props (.ref_clk,
    .reset_n, .bus, .rdata, .stop_mode, .irq_ack, .irq_req,
    .timer_zero_run, .timer_one_run, .wake_req, .osc_enable);

// [testbench/two_level_interrupt_controller_tb_top.sv]
// bench: registers, priority, vectors and wake of the controller
module two_level_interrupt_controller_tb_top
    import irq_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    reg_bus_t    bus     = '0;
    logic [10:0] src     = '0; // t0 t1 t2 s1 s2 i2c mem bkp dbg stop wd
    logic [6:0]  line    = '0;
    logic [1:0]  gpio    = 2'b10;
    logic [7:0]  rdata;
    irq_req_t    irq_req;
    logic        irq_ack, irq_return, wake_req;
    logic        osc;
    logic [1:0]  run; // timer one, timer zero run outputs
    int          n_fail      = 0;
    int          check_count = 0;
    localparam logic [7:0] OFS [10] = '{8'h88, 8'h91, 8'hA8, 8'hB8,
        8'hE8, 8'hF8, 8'h9D, 8'hC5, 8'h9F, 8'h00};
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    two_level_interrupt_controller #(.GPIO_PINS(2)) u_dut (
        .ref_clk, .reset_n, .bus, .rdata, .irq_ack, .irq_return, .irq_req,
        .wake_req, .timer_zero_overflow(src[0]), .timer_one_overflow(src[1]),
        .timer_two_overflow_flag(src[2]), .serial_one_irq(src[3]),
        .serial_two_irq(src[4]), .i2c_host_event(src[5]),
        .mem_error_irq(src[6]), .breakpoint_irq(src[7]),
        .debug_port_irq(src[8]), .stop_mode(src[9]), .watchdog_flag(src[10]),
        .line_flags_in(line), .gpio_pins(gpio), .gpio_group_b_sel(2'b10),
        .gpio_rise_en(2'b01), .gpio_fall_en(2'b10), .timer_zero_run(run[0]),
        .timer_one_run(run[1]), .osc_enable(osc));
    cpu_seq_model u_cpu (.ref_clk, .reset_n, .irq_req, .irq_ack,
        .irq_return);
    ////////////////////////////////////////////////////////////////////
    // comparisons and bus cycles
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
        chk8($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic pulse(int b);
        @(posedge ref_clk);
        src[b] <= 1'b1;
        @(posedge ref_clk);
        src[b] <= 1'b0;
    endtask
    // sources in drop are released on the ack edge, as a routine would
    task automatic wait_vec(logic [15:0] e, logic [10:0] drop);
        int i;
        for (i = 0; i < 60 && irq_req.valid !== 1'b1; i++) @(negedge ref_clk);
        chk8("valid", 8'h01, {7'h0, irq_req.valid});
        chk16("vector", e, irq_req.vector);
        for (i = 0; i < 60 && irq_ack !== 1'b1; i++) @(negedge ref_clk);
        chk8("ack", 8'h01, {7'h0, irq_ack});
        @(posedge ref_clk);
        src <= src & ~drop;
    endtask
    task automatic watch_wake(output logic s);
        s = 1'b0;
        repeat (10) begin
            @(negedge ref_clk);
            if (wake_req === 1'b1) s = 1'b1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        foreach (OFS[i])
            rd(OFS[i], OFS[i] == 8'h9F ? 8'hFF : 8'h00);
        wr(8'hA8, 8'h5A);
        rd(8'hA8, 8'h5A);
        wr(8'hB8, 8'hFF);
        rd(8'hB8, 8'h7F);
        wr(8'hE8, 8'hA5);
        rd(8'hE8, 8'hA5);
        wr(8'hF8, 8'h3C);
        rd(8'hF8, 8'h3C);
        wr(8'h88, 8'h5A);
        rd(8'h88, 8'h50);
        chk8("run bits", 8'h03, {6'h0, run});
        foreach (OFS[i]) if (i < 6) wr(OFS[i], 8'h00);
    endtask
    task automatic t_ext();
        line <= 7'h77;
        rd(8'h91, 8'hEE);
        wr(8'h91, 8'h00);
        rd(8'h91, 8'hEE);
        line <= 7'h00;
        wr(8'h91, 8'hFF);
        rd(8'h91, 8'h00);
        pulse(5);
        wr(8'h91, 8'h01);
        rd(8'h91, 8'h01);
        wr(8'h91, 8'h00);
        rd(8'h91, 8'h00);
    endtask
    // high beats low, low waits, high preempts low, returns unwind
    task automatic t_prio();
        u_cpu.ack_dly = 8;
        wr(8'hA8, 8'hFF);
        wr(8'hB8, 8'h08);
        pulse(1);
        src[3:2] <= 2'b11;
        wait_vec(16'h001B, 11'h000);
        u_cpu.ack_dly = 2;
        rd(8'h88, 8'h00);
        rd(8'hC5, 8'h40);
        repeat (6) @(negedge ref_clk);
        chk16("request", 16'h0000, {15'h0, irq_req.valid});
        u_cpu.do_ret();
        wait_vec(16'h0023, 11'h000);
        rd(8'hC5, 8'h20);
        pulse(1);
        wait_vec(16'h001B, 11'h00C);
        rd(8'hC5, 8'h60);
        u_cpu.do_ret();
        rd(8'hC5, 8'h20);
        u_cpu.do_ret();
        rd(8'hC5, 8'h00);
        wr(8'hB8, 8'h00);
    endtask
    // extended lines: high level line 8 beats the low level watchdog
    task automatic t_ext_irq();
        wr(8'hA8, 8'h80);
        wr(8'hE8, 8'h90);
        wr(8'hF8, 8'h80);
        src[10] <= 1'b1;
        line[6] <= 1'b1;
        wait_vec(16'h0073, 11'h000);
        line[6] <= 1'b0;
        u_cpu.do_ret();
        wait_vec(16'h005B, 11'h400);
        u_cpu.do_ret();
        wr(8'hE8, 8'h00);
        wr(8'hF8, 8'h00);
        wr(8'hA8, 8'h00);
    endtask
    task automatic t_vectors();
        wr(8'hA8, 8'h00);
        src[8:7] <= 2'b11;
        wait_vec({TOP_NIBBLE_64K, 12'h0C0}, 11'h180);
        u_cpu.do_ret();
        src[7] <= 1'b1;
        wait_vec({TOP_NIBBLE_64K, 12'h080}, 11'h080);
        u_cpu.do_ret();
        wr(8'hA8, 8'h80);
        src[6] <= 1'b1;
        wait_vec(16'h007B, 11'h040);
        u_cpu.do_ret();
        wr(8'h9D, 8'h20);
        wr(8'hA8, 8'h82);
        pulse(0);
        wait_vec({TOP_NIBBLE_64K, 12'h00B}, 11'h000);
        rd(8'h88, 8'h00);
        u_cpu.do_ret();
        wr(8'h9D, 8'h00);
    endtask
    task automatic t_gpio();
        wr(8'hA8, 8'h85);
        wr(8'h88, 8'h0A);
        rd(8'h88, 8'h00);
        gpio[0] <= 1'b1;
        wait_vec(16'h0003, 11'h000);
        rd(8'h88, 8'h02);
        wr(8'h88, 8'h00);
        u_cpu.do_ret();
        gpio[1] <= 1'b0;
        wait_vec(16'h0013, 11'h000);
        rd(8'h88, 8'h08);
        wr(8'h88, 8'h00);
        u_cpu.do_ret();
        wr(8'hA8, 8'h00);
    endtask
    task automatic t_wake();
        logic s;
        src[9] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk8("oscillator", 8'h00, {7'h0, osc});
        line[0] <= 1'b1;
        watch_wake(s);
        chk8("wake", 8'h01, {7'h0, s});
        chk16("request", 16'h0000, {15'h0, irq_req.valid});
        line[0] <= 1'b0;
        wr(8'h9F, 8'h00);
        line[0] <= 1'b1;
        watch_wake(s);
        chk8("masked wake", 8'h00, {7'h0, s});
        line[0] <= 1'b0;
        src[9] <= 1'b0;
        wr(8'h9F, 8'hFF);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // the whole run needs a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_regs();
        t_ext();
        t_prio();
        t_ext_irq();
        t_vectors();
        t_gpio();
        t_wake();
        conclude();
    end
endmodule
